// *** core/acs_top.sv ***
// Conversion sequencer with Wishbone register file for a 12-bit SAR converter
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_top #(
    parameter int RES_BITS = 12,
    parameter int DIV_BITS = 3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cmp_i,
    input  wire logic        stack_room_i,
    output logic             conv_power_o,
    output logic             conv_reset_o,
    output logic             sample_o,
    output logic             conv_busy_o,
    output logic [11:0]      sar_dac_o,
    output logic             ext_connect_o,
    output logic [3:0]       ext_channel_o,
    output logic [2:0]       internal_src_o,
    output logic [7:0]       analog_pin_en_o,
    output logic [1:0]       ref_src_o,
    output logic [2:0]       ref_gain_o,
    output logic             ext_ref_pin_func_o,
    output logic             irq_req_o
);

    initial begin
        if (RES_BITS != 12 || DIV_BITS != 3) begin
            $error("acs_top serves only a 12-bit result and a 3-bit divider field");
        end
    end

    // Register state
    logic [7:0]  conv_ctrl_first_r;
    logic [7:0]  conv_ctrl_second_r;
    logic [7:0]  ctrl_ref_r;
    logic [7:0]  analog_pin_enable_reg_r;
    logic        conv_irq_enable_r;
    logic        global_irq_enable_r;
    logic        conv_irq_flag_r;
    logic [11:0] result_r;
    logic        ack_r;
    logic [31:0] dat_r;

    // Sequencer state
    acs_pkg::acs_state_t state_r;
    acs_pkg::acs_state_t state_nxt;
    logic [6:0]  div_cnt_r;
    logic [4:0]  tick_cnt_r;
    logic [4:0]  tick_cnt_nxt;
    logic [11:0] sar_r;
    logic [11:0] sar_nxt;
    logic [3:0]  bit_idx_r;
    logic [3:0]  bit_idx_nxt;
    logic        cmp_meta_r;
    logic        cmp_sync_r;

    // Field views
    wire logic       start_bit     = conv_ctrl_first_r[`ACS_BIT_START];
    wire logic       power_on      = conv_ctrl_first_r[`ACS_BIT_POWER_ON];
    wire logic       format_sel    = conv_ctrl_first_r[`ACS_BIT_FORMAT];
    wire logic [3:0] channel_sel   = conv_ctrl_first_r[3:0];
    wire logic [2:0] clk_div_sel   = conv_ctrl_second_r[2:0];
    wire logic [2:0] input_src_sel = conv_ctrl_second_r[7:5];
    wire logic [3:0] reference_sel = ctrl_ref_r[3:0];
    wire logic       busy          = (state_r == acs_pkg::ACS_ST_SAMPLE)
                                   || (state_r == acs_pkg::ACS_ST_CONVERT);

    // Bus decode
    wire logic       bus_req   = wb_cyc_i && wb_stb_i && !ack_r;
    wire logic       bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    wire logic [7:0] wr_byte   = wb_dat_i[7:0];
    wire logic       wr_first  = bus_wr && (wb_adr_i == `ACS_OFF_CTRL_FIRST);
    wire logic       wr_second = bus_wr && (wb_adr_i == `ACS_OFF_CTRL_SECOND);
    wire logic       wr_ref    = bus_wr && (wb_adr_i == `ACS_OFF_CTRL_REF);
    wire logic       wr_pins   = bus_wr && (wb_adr_i == `ACS_OFF_PIN_ENABLE);
    wire logic       wr_irq    = bus_wr && (wb_adr_i == `ACS_OFF_IRQ);

    // Divider mask: 2**sel system clocks per converter clock
    wire logic [6:0] div_mask  = 7'(({1'b0, 7'h7f} >> (3'h7 - clk_div_sel)) & 8'h7f);
    wire logic       conv_tick = ((div_cnt_r & div_mask) == div_mask);

    wire logic       seq_done  = (state_r == acs_pkg::ACS_ST_CONVERT) && conv_tick
                                 && (bit_idx_r == 4'h0) && power_on && !start_bit;
    wire logic [11:0] sar_final = cmp_sync_r ? sar_r : (sar_r & ~(12'h001 << bit_idx_r));

    function automatic logic [15:0] acs_arrange(input logic fmt, input logic [11:0] res);
        // Left-justified when clear, right-justified when set
        acs_arrange = fmt ? {4'h0, res} : {res, 4'h0};
    endfunction

    wire logic [15:0] arranged = acs_arrange(format_sel, result_r);

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (wb_adr_i)
            `ACS_OFF_CTRL_FIRST:  rd_byte = {conv_ctrl_first_r[7], busy,
                                             conv_ctrl_first_r[5:0]};
            `ACS_OFF_CTRL_SECOND: rd_byte = conv_ctrl_second_r;
            `ACS_OFF_CTRL_REF:    rd_byte = {3'h0, ctrl_ref_r[4:0]};
            `ACS_OFF_PIN_ENABLE:  rd_byte = analog_pin_enable_reg_r;
            `ACS_OFF_RESULT_HIGH: rd_byte = arranged[15:8];
            `ACS_OFF_RESULT_LOW:  rd_byte = arranged[7:0];
            `ACS_OFF_IRQ:         rd_byte = {5'h00, conv_irq_flag_r,
                                             global_irq_enable_r, conv_irq_enable_r};
            default:              rd_byte = 8'h00;
        endcase
    end

    // Bus slave: one wait state, ack for every address, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            dat_r <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Writes; the busy bit is read-only and ignored on write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_ctrl_first_r       <= `ACS_RST_CTRL_FIRST;
            conv_ctrl_second_r      <= `ACS_RST_CTRL_SECOND;
            ctrl_ref_r              <= `ACS_RST_CTRL_REF;
            analog_pin_enable_reg_r <= `ACS_RST_PIN_ENABLE;
            conv_irq_enable_r       <= 1'b0;
            global_irq_enable_r     <= 1'b0;
        end else begin
            if (wr_first) begin
                conv_ctrl_first_r <= wr_byte;
            end
            if (wr_second) begin
                conv_ctrl_second_r <= wr_byte;
            end
            if (wr_ref) begin
                ctrl_ref_r <= wr_byte;
            end
            if (wr_pins) begin
                analog_pin_enable_reg_r <= wr_byte;
            end
            if (wr_irq) begin
                conv_irq_enable_r   <= wr_byte[`ACS_BIT_IRQ_EN];
                global_irq_enable_r <= wr_byte[`ACS_BIT_GLOBAL_EN];
            end
        end
    end

    // Sticky flag: completion in the cycle of a clearing write still sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_irq_flag_r <= 1'b0;
        end else if (seq_done) begin
            conv_irq_flag_r <= 1'b1;
        end else if (wr_irq && !wr_byte[`ACS_BIT_IRQ_FLAG]) begin
            conv_irq_flag_r <= 1'b0;
        end
    end

    // Comparator level from the analog side is asynchronous
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= cmp_i;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    always_comb begin
        state_nxt    = state_r;
        tick_cnt_nxt = tick_cnt_r;
        sar_nxt      = sar_r;
        bit_idx_nxt  = bit_idx_r;
        case (state_r)
            acs_pkg::ACS_ST_IDLE: begin
                if (start_bit) begin
                    state_nxt = acs_pkg::ACS_ST_HELD;
                end
            end
            acs_pkg::ACS_ST_HELD: begin
                tick_cnt_nxt = 5'h00;
                if (!start_bit) begin
                    state_nxt = acs_pkg::ACS_ST_SAMPLE;
                end
            end
            acs_pkg::ACS_ST_SAMPLE: begin
                if (conv_tick) begin
                    tick_cnt_nxt = tick_cnt_r + 5'h01;
                    if (tick_cnt_r == `ACS_SAMPLE_TICKS - 5'h01) begin
                        state_nxt    = acs_pkg::ACS_ST_CONVERT;
                        tick_cnt_nxt = 5'h00;
                        sar_nxt      = 12'h800;
                        bit_idx_nxt  = 4'hb;
                    end
                end
            end
            acs_pkg::ACS_ST_CONVERT: begin
                if (conv_tick) begin
                    // Keep the trial bit while the input is at or above the DAC level;
                    // the half-LSB offset of the steps is built into the analog DAC
                    sar_nxt      = sar_final;
                    tick_cnt_nxt = tick_cnt_r + 5'h01;
                    if (bit_idx_r == 4'h0) begin
                        state_nxt = acs_pkg::ACS_ST_IDLE;
                    end else begin
                        bit_idx_nxt = bit_idx_r - 4'h1;
                        sar_nxt     = sar_final | (12'h001 << (bit_idx_r - 4'h1));
                    end
                end
            end
            default: begin
                state_nxt = acs_pkg::ACS_ST_IDLE;
            end
        endcase
        // A new start pulse aborts whatever runs
        if (start_bit) begin
            state_nxt = acs_pkg::ACS_ST_HELD;
        end
        if (!power_on) begin
            state_nxt = acs_pkg::ACS_ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= acs_pkg::ACS_ST_IDLE;
            div_cnt_r  <= 7'h00;
            tick_cnt_r <= 5'h00;
            sar_r      <= 12'h000;
            bit_idx_r  <= 4'h0;
            result_r   <= 12'h000;
        end else begin
            state_r    <= state_nxt;
            // Divider restarts with each sampling so every conversion is 16 full periods
            div_cnt_r  <= (state_r == acs_pkg::ACS_ST_HELD) ? 7'h00 : div_cnt_r + 7'h01;
            tick_cnt_r <= tick_cnt_nxt;
            sar_r      <= sar_nxt;
            bit_idx_r  <= bit_idx_nxt;
            if (seq_done && power_on && !start_bit) begin
                result_r <= sar_final & `ACS_RESULT_FULL_SCALE;
            end
        end
    end

    // Reference code decode
    acs_pkg::acs_ref_src_t ref_src;
    logic [2:0]            ref_gain;
    always_comb begin
        ref_src  = acs_pkg::ACS_REF_SUPPLY;
        ref_gain = 3'h1;
        case (reference_sel)
            4'h1:    ref_src = acs_pkg::ACS_REF_EXTERNAL;
            4'h2, 4'h3, 4'h4: begin
                ref_src  = acs_pkg::ACS_REF_EXTERNAL;
                ref_gain = reference_sel[2:0];
            end
            4'ha, 4'hb, 4'hc: begin
                ref_src  = acs_pkg::ACS_REF_BANDGAP;
                ref_gain = 3'(reference_sel - 4'h8);
            end
            default: ref_src = acs_pkg::ACS_REF_SUPPLY;
        endcase
    end

    wire logic use_ext = (input_src_sel == `ACS_SRC_EXTERNAL);
    wire logic irq_now = conv_irq_flag_r && conv_irq_enable_r
                         && global_irq_enable_r && stack_room_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_power_o   <= 1'b0;
            conv_reset_o   <= 1'b0;
            sample_o       <= 1'b0;
            conv_busy_o    <= 1'b0;
            ext_connect_o  <= 1'b0;
            ext_channel_o  <= 4'h0;
            internal_src_o <= 3'h0;
            ref_src_o      <= 2'h0;
            ref_gain_o     <= 3'h1;
            irq_req_o      <= 1'b0;
        end else begin
            conv_power_o   <= power_on;
            conv_reset_o   <= start_bit;
            sample_o       <= (state_r == acs_pkg::ACS_ST_SAMPLE);
            conv_busy_o    <= busy;
            ext_connect_o  <= power_on && use_ext;
            ext_channel_o  <= use_ext ? channel_sel : 4'h0;
            internal_src_o <= input_src_sel;
            ref_src_o      <= ref_src;
            ref_gain_o     <= ref_gain;
            irq_req_o      <= irq_now;
        end
    end

    assign wb_dat_o           = dat_r;
    assign wb_ack_o           = ack_r;
    assign sar_dac_o          = sar_r;
    assign analog_pin_en_o    = analog_pin_enable_reg_r;
    assign ext_ref_pin_func_o = ctrl_ref_r[`ACS_BIT_EXT_REF_FUNC];

endmodule

// *** core/acs_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_OFF_CTRL_FIRST    8'h00
`define ACS_OFF_CTRL_SECOND   8'h04
`define ACS_OFF_CTRL_REF      8'h08
`define ACS_OFF_PIN_ENABLE    8'h0c
`define ACS_OFF_RESULT_HIGH   8'h10
`define ACS_OFF_RESULT_LOW    8'h14
`define ACS_OFF_IRQ           8'h18

`define ACS_BIT_START         7
`define ACS_BIT_BUSY          6
`define ACS_BIT_POWER_ON      5
`define ACS_BIT_FORMAT        4
`define ACS_BIT_EXT_REF_FUNC  4
`define ACS_BIT_IRQ_EN        0
`define ACS_BIT_GLOBAL_EN     1
`define ACS_BIT_IRQ_FLAG      2

`define ACS_RST_CTRL_FIRST    8'h00
`define ACS_RST_CTRL_SECOND   8'h00
`define ACS_RST_CTRL_REF      8'h00
`define ACS_RST_PIN_ENABLE    8'h00

`define ACS_SRC_EXTERNAL      3'h0
`define ACS_SAMPLE_TICKS      5'h04
`define ACS_CONVERT_TICKS     5'h0c
`define ACS_RESULT_FULL_SCALE 12'hfff

`endif

// *** core/acs_pkg.sv ***
// Types shared by the conversion sequencer
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_ST_IDLE,
        ACS_ST_HELD,
        ACS_ST_SAMPLE,
        ACS_ST_CONVERT
    } acs_state_t;

    typedef enum logic [1:0] {
        ACS_REF_SUPPLY,
        ACS_REF_EXTERNAL,
        ACS_REF_BANDGAP
    } acs_ref_src_t;
endpackage

// *** tb/acs_top_props.sv ***
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_top_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        stack_room_i,
    input wire logic        conv_power_o,
    input wire logic        conv_reset_o,
    input wire logic        sample_o,
    input wire logic        conv_busy_o,
    input wire logic        ext_connect_o,
    input wire logic [3:0]  ext_channel_o,
    input wire logic [2:0]  internal_src_o,
    input wire logic [1:0]  ref_src_o,
    input wire logic [2:0]  ref_gain_o,
    input wire logic        irq_req_o
);
    logic [7:0] conv_cnt_r;
    logic [7:0] conv_cnt_nxt;
    wire        converting = conv_busy_o && !sample_o;
    // Saturates so that slow divider settings cannot wrap the count
    assign conv_cnt_nxt = !converting ? 8'h00 : (&conv_cnt_r) ? conv_cnt_r : conv_cnt_r + 8'h01;
    always_ff @(posedge clk_i) begin
        if (rst_i) conv_cnt_r <= 8'h00;
        else conv_cnt_r <= conv_cnt_nxt;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence held_reset;
        conv_reset_o ##1 conv_reset_o;
    endsequence
    sequence power_off_settled;
        (!conv_power_o) [*3];
    endsequence
    chk_ack_follows_req: assert property (bus_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_power_gates_busy: assert property (power_off_settled |-> !conv_busy_o)
        else $error("busy while powered off");
    chk_internal_disconnects: assert property (
        internal_src_o != 3'h0 |-> !ext_connect_o && ext_channel_o == 4'h0)
        else $error("external channel connected with internal source");
    chk_ref_code_legal: assert property (ref_src_o != 2'h3 && ref_gain_o inside {[1:4]})
        else $error("reference decode out of range");
    chk_irq_needs_room: assert property (irq_req_o |-> $past(stack_room_i))
        else $error("interrupt request without stack room");
    chk_reset_holds: assert property (held_reset |-> !sample_o && !conv_busy_o)
        else $error("converter active while start held");
    chk_sample_in_busy: assert property (sample_o |-> conv_busy_o)
        else $error("sampling without busy");
    chk_convert_length: assert property (
        $fell(conv_busy_o) && conv_power_o && !conv_reset_o |-> conv_cnt_r >= 8'h0c)
        else $error("conversion phase shorter than twelve ticks");
endmodule
bind acs_top acs_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .stack_room_i(stack_room_i), .conv_power_o(conv_power_o), .conv_reset_o(conv_reset_o),
    .sample_o(sample_o), .conv_busy_o(conv_busy_o), .ext_connect_o(ext_connect_o),
    .ext_channel_o(ext_channel_o), .internal_src_o(internal_src_o), .ref_src_o(ref_src_o),
    .ref_gain_o(ref_gain_o), .irq_req_o(irq_req_o));

// *** tb/test_adc_conversion_sequencer.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic        cmp_i = 1'b0;
    logic        stack_room_i = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, conv_power_o, conv_reset_o, sample_o, conv_busy_o;
    logic        ext_connect_o, ext_ref_pin_func_o, irq_req_o;
    logic [11:0] sar_dac_o;
    logic [3:0]  ext_channel_o;
    logic [2:0]  internal_src_o, ref_gain_o;
    logic [7:0]  analog_pin_en_o;
    logic [1:0]  ref_src_o;
    logic [31:0] rd_q;
    int          failures = 0;
    int          comparisons = 0;
    always #5 clk_i = ~clk_i;
    acs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .stack_room_i(stack_room_i),
        .conv_power_o(conv_power_o), .conv_reset_o(conv_reset_o), .sample_o(sample_o),
        .conv_busy_o(conv_busy_o), .sar_dac_o(sar_dac_o), .ext_connect_o(ext_connect_o),
        .ext_channel_o(ext_channel_o), .internal_src_o(internal_src_o),
        .analog_pin_en_o(analog_pin_en_o), .ref_src_o(ref_src_o), .ref_gain_o(ref_gain_o),
        .ext_ref_pin_func_o(ext_ref_pin_func_o), .irq_req_o(irq_req_o));
    task automatic close_out;
        $display("compared %0d, mismatched %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_up(input string nm);
        failures++;
        $display("BAD %s expected done seen timeout", nm);
        close_out;
    endtask
    // One classic cycle; waits for ack, takes data at that edge, then idles a cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 20) give_up("ack");
            @(posedge clk_i);
        end
        rd_q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_lvl(input logic l);
        int n = 0;
        while (conv_busy_o !== l) begin
            n++;
            if (n > 400) give_up("busy wait");
            @(posedge clk_i);
        end
    endtask
    task automatic busy_len(output int c, output int s);
        wait_lvl(1'b1);
        c = 0;
        s = 0;
        while (conv_busy_o === 1'b1 && c < 2000) begin
            c++;
            if (sample_o === 1'b1) s++;
            @(posedge clk_i);
        end
    endtask
    task automatic pulse(input logic [7:0] base);
        bus(1'b1, 8'h00, base | 8'h80);
        bus(1'b1, 8'h00, base);
    endtask
    task automatic t_reset;
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, a[7:0], 8'h00);
            chk("reset reg", 32'h0, rd_q);
        end
        chk("reset gain", 3'h1, ref_gain_o);
    endtask
    task automatic t_polled;
        int c, s;
        bus(1'b1, 8'h04, 8'h03);
        bus(1'b1, 8'h0c, 8'h01);
        bus(1'b1, 8'h00, 8'h20);
        @(posedge clk_i);
        chk("connect", 1'b1, ext_connect_o);
        chk("channel", 4'h0, ext_channel_o);
        chk("power", 1'b1, conv_power_o);
        chk("pins", 8'h01, analog_pin_en_o);
        cmp_i <= 1'b1;
        pulse(8'h20);
        busy_len(c, s);
        chk("busy cycles", 128, c);
        chk("sample cycles", 32, s);
        chk("dac full", 32'hfff, sar_dac_o);
        bus(1'b0, 8'h00, 8'h00);
        chk("busy bit", 1'b0, rd_q[6]);
        bus(1'b0, 8'h10, 8'h00);
        chk("high", 32'hff, rd_q);
        bus(1'b0, 8'h14, 8'h00);
        chk("low", 32'hf0, rd_q);
        bus(1'b1, 8'h00, 8'h30);
        bus(1'b0, 8'h10, 8'h00);
        chk("high alt", 32'h0f, rd_q);
        bus(1'b0, 8'h14, 8'h00);
        chk("low alt", 32'hff, rd_q);
    endtask
    task automatic t_irq;
        bus(1'b0, 8'h18, 8'h00);
        chk("flag set", 32'h04, rd_q);
        stack_room_i <= 1'b0;
        bus(1'b1, 8'h18, 8'h07);
        repeat (3) @(posedge clk_i);
        chk("irq no room", 1'b0, irq_req_o);
        stack_room_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("irq on", 1'b1, irq_req_o);
        bus(1'b1, 8'h18, 8'h05);
        repeat (3) @(posedge clk_i);
        chk("irq no global", 1'b0, irq_req_o);
        bus(1'b1, 8'h18, 8'h03);
        bus(1'b0, 8'h18, 8'h00);
        chk("flag cleared", 32'h03, rd_q);
    endtask
    task automatic t_abort;
        int c, s;
        bus(1'b1, 8'h04, 8'h00);
        cmp_i <= 1'b0;
        pulse(8'h20);
        wait_lvl(1'b1);
        bus(1'b0, 8'h00, 8'h00);
        chk("busy polled", 1'b1, rd_q[6]);
        bus(1'b1, 8'h00, 8'ha0);
        @(posedge clk_i);
        chk("held reset", 1'b1, conv_reset_o);
        chk("aborted", 1'b0, conv_busy_o);
        bus(1'b1, 8'h00, 8'h20);
        busy_len(c, s);
        chk("restart cycles", 16, c);
        chk("restart sample", 4, s);
        chk("dac zero", 32'h0, sar_dac_o);
        bus(1'b0, 8'h10, 8'h00);
        chk("zero code", 32'h0, rd_q);
        chk("irq done", 1'b1, irq_req_o);
        bus(1'b1, 8'h18, 8'h00);
        pulse(8'h20);
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b1, 8'h18, 8'h03);
        wait_lvl(1'b1);
        bus(1'b1, 8'h00, 8'h00);
        repeat (20) @(posedge clk_i);
        chk("off busy", 1'b0, conv_busy_o);
        bus(1'b0, 8'h18, 8'h00);
        chk("off no flag", 32'h03, rd_q);
    endtask
    task automatic t_source;
        logic [3:0] code[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'hb, 4'hc, 4'hf};
        logic [4:0] exp[10] = '{5'h01, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h01, 5'h12, 5'h13,
            5'h14, 5'h01};
        bus(1'b1, 8'h04, 8'h20);
        bus(1'b1, 8'h00, 8'h23);
        @(posedge clk_i);
        chk("int connect", 1'b0, ext_connect_o);
        chk("int channel", 4'h0, ext_channel_o);
        chk("int source", 3'h1, internal_src_o);
        bus(1'b1, 8'h04, 8'h00);
        @(posedge clk_i);
        chk("ext channel", 4'h3, ext_channel_o);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 8'h08, {3'h0, i == 1, code[i]});
            @(posedge clk_i);
            chk("ref", exp[i], {ref_src_o, ref_gain_o});
            chk("ref pin", i == 1, ext_ref_pin_func_o);
        end
        bus(1'b1, 8'h1c, 8'hff);
        bus(1'b0, 8'h1c, 8'h00);
        chk("unmapped", 32'h0, rd_q);
        bus(1'b1, 8'h00, 8'h40);
        bus(1'b0, 8'h00, 8'h00);
        chk("busy read only", 32'h0, rd_q);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_polled;
        t_irq;
        t_abort;
        t_source;
        close_out;
    end
endmodule
